// ---- shared/chan_port_defines.svh ----
// constant offsets, bit positions, codes and reset values for the
// channel interface control port; included by the control port module.
`ifndef CHAN_PORT_DEFINES_SVH
`define CHAN_PORT_DEFINES_SVH

// strobe channel bit numbers, channel numbering
`define STB_START       0
`define STB_END         1
`define STB_FUNC        2
`define STB_CLEAR       3
`define STB_SEND        4
`define STB_TABLE       5
`define STB_ADDR_SEL    6

// control word bit numbers, channel numbering
`define CW_COMPARE      0
`define CW_CONNECT      2
`define FN_CONVERT      0
`define FN_WRITE        1
`define FN_ALT_BANK     3
`define FN_NO_MEM       4
`define FN_HALT_ERR     5
`define FN_REVERSE      6

// connect codes, channel bits C..F
`define CONNECT_CH0     4'hc
`define CONNECT_CH1     4'hd

// address geometry
`define PAGE_LAST       11'h7ff
`define PAGE_FIRST      11'h000
`define TABLE_LOW       8'h00

// reset values
`define ADDR_RESET      15'h0000
`define PHASE_RESET     3'h0
`define STATUS_RESET    16'h0000
`define CODE_RESET      12'h000

`endif

// ---- shared/chan_port_pkg.sv ----
// types shared by the channel interface control port modules
// assumes the defines header is compiled alongside
package chan_port_pkg;

  typedef enum logic {
    XFER_IDLE,
    XFER_RUN
  } xfer_state_t;

  typedef struct packed {
    logic convert;
    logic write;
    logic alt_bank;
    logic no_mem;
    logic halt_err;
    logic reverse;
  } xfer_cfg_t;

  typedef struct packed {
    logic        is_connect;
    logic [11:0] code;
  } periph_code_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [14:0] addr;
  } mem_req_t;

endpackage

// ---- design/strobe_edges.sv ----
// edge detection for the strobe channel bits
// assumes levels synchronous to core_clk; enable gates both edges
`timescale 1ns/1ps
module strobe_edges (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       enable,
  input  wire logic [6:0] level,
  output logic      [6:0] rise,
  output logic      [6:0] fall
);

  logic [6:0] prev;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev <= 7'h00;
    end else begin
      prev <= level;
    end
  end

  assign rise = enable ? (level & ~prev) : 7'h00;
  assign fall = enable ? (~level & prev) : 7'h00;

endmodule // strobe_edges

// ---- design/channel_interface_control_port.sv ----
// channel interface control port: control, strobe and status channels
// assumes all inputs synchronous to core_clk; data path is external
`timescale 1ns/1ps
`include "chan_port_defines.svh"
module channel_interface_control_port
  import chan_port_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         channel_select,
  input  wire logic [15:0]  control_word,
  input  wire logic [15:0]  strobe_word,
  output logic      [15:0]  status_word,
  input  wire logic [3:0]   irq_lines,
  input  wire logic [3:0]   assembly_count,
  input  wire logic         word_strobe,
  input  wire logic         end_of_record,
  input  wire logic         mem_parity_err,
  input  wire logic         read_parity_err,
  input  wire logic         write_parity_err,
  output mem_req_t          mem_bus,
  output xfer_cfg_t         xfer_cfg,
  output logic      [14:0]  table_address,
  output periph_code_t      periph_code,
  output logic              periph_code_send,
  output logic              transfer_active,
  output logic              page_empty,
  output logic              address_compare
);

  // channel bit n, bit 0 most significant
  function automatic logic chan_bit(input logic [15:0] w,
                                    input int unsigned n);
    chan_bit = w[15 - n];
  endfunction

  // next in-page address, counting up or down
  function automatic logic [10:0] step_low(input logic [10:0] a,
                                           input logic        down);
    step_low = down ? 11'(a - 11'h001) : 11'(a + 11'h001);
  endfunction

  xfer_state_t  state;
  xfer_state_t  next_state;
  logic [14:0]  cur_addr;
  logic [14:0]  next_cur_addr;
  logic [10:0]  end_low;
  logic [3:0]   next_page;
  logic         compare_en;
  logic [2:0]   phase_count;
  logic         sticky_mem_err;
  logic         sticky_read_err;
  logic [6:0]   stb_rise;
  logic [6:0]   stb_fall;

  // connection decode
  wire  [3:0]  connect_code  = strobe_word[3:0];
  wire  [3:0]  own_code      = channel_select ? `CONNECT_CH1
                                              : `CONNECT_CH0;
  wire         connected     = (connect_code == own_code);

  wire  [6:0]  stb_level     = {chan_bit(strobe_word, `STB_ADDR_SEL),
                                chan_bit(strobe_word, `STB_TABLE),
                                chan_bit(strobe_word, `STB_SEND),
                                chan_bit(strobe_word, `STB_CLEAR),
                                chan_bit(strobe_word, `STB_FUNC),
                                chan_bit(strobe_word, `STB_END),
                                chan_bit(strobe_word, `STB_START)};

  strobe_edges u_strobe_edges (
    .core_clk (core_clk),
    .rst      (rst),
    .enable   (connected),
    .level    (stb_level),
    .rise     (stb_rise),
    .fall     (stb_fall)
  );

  // strobe decode
  wire         load_start    = stb_rise[`STB_START];
  wire         load_end      = stb_rise[`STB_END];
  wire         load_func     = stb_rise[`STB_FUNC];
  wire         load_table    = stb_rise[`STB_TABLE];
  wire         send_code     = stb_fall[`STB_SEND];
  wire         prog_clear    = connected
                               & stb_level[`STB_CLEAR];
  wire         addr_sel      = connected
                               & stb_level[`STB_ADDR_SEL];

  // control word fields, address fields complemented on arrival
  wire  [14:0] cw_addr       = ~control_word[14:0];
  wire         cw_compare    = chan_bit(control_word, `CW_COMPARE);
  wire  [10:0] cw_end_low    = cw_addr[10:0];
  wire  [3:0]  cw_next_page  = cw_addr[14:11];
  wire  [6:0]  cw_table_hi   = ~control_word[14:8];
  wire         cw_is_connect = chan_bit(control_word, `CW_CONNECT);
  wire  [11:0] cw_code       = control_word[11:0];

  wire  xfer_cfg_t cw_cfg    = '{
    convert:  chan_bit(control_word, `FN_CONVERT),
    write:    chan_bit(control_word, `FN_WRITE),
    alt_bank: chan_bit(control_word, `FN_ALT_BANK),
    no_mem:   chan_bit(control_word, `FN_NO_MEM),
    halt_err: chan_bit(control_word, `FN_HALT_ERR),
    reverse:  chan_bit(control_word, `FN_REVERSE)
  };

  // transfer progress decode
  wire         running       = (state == XFER_RUN);
  wire         word_step     = running & word_strobe;
  wire         count_down    = xfer_cfg.reverse & ~xfer_cfg.write;
  wire  [10:0] page_edge     = count_down ? `PAGE_FIRST
                                          : `PAGE_LAST;
  wire         at_page_edge  = (cur_addr[10:0] == page_edge);
  wire         end_match     = (cur_addr[10:0] == end_low)
                               & (cur_addr[14:11] == next_page);
  wire         compare_stop  = word_step & xfer_cfg.write
                               & compare_en & end_match;
  wire         record_stop   = running & end_of_record;
  wire         any_parity    = (mem_parity_err & xfer_cfg.write)
                               | read_parity_err
                               | write_parity_err;
  wire         error_stop    = running & xfer_cfg.halt_err
                               & any_parity;
  wire         stop_now      = compare_stop | record_stop | error_stop;
  wire  [2:0]  phase_step    = xfer_cfg.alt_bank ? 3'h2 : 3'h1;
  wire         page_jump     = word_step & at_page_edge & ~compare_stop;

  // next address: lower bits step, page jumps to loaded next page
  always_comb begin
    next_cur_addr = cur_addr;
    if (load_start) begin
      next_cur_addr = cw_addr;
    end else if (word_step) begin
      if (at_page_edge) begin
        next_cur_addr = {next_page,
                         count_down ? `PAGE_LAST : `PAGE_FIRST};
      end else begin
        next_cur_addr = {cur_addr[14:11],
                         step_low(cur_addr[10:0], count_down)};
      end
    end
  end

  // transfer state
  always_comb begin
    next_state = state;
    case (state)
      XFER_IDLE: begin
        if (load_func && !prog_clear) begin
          next_state = XFER_RUN;
        end
      end
      XFER_RUN: begin
        if (prog_clear || stop_now) begin
          next_state = XFER_IDLE;
        end else if (load_func) begin
          next_state = XFER_RUN;
        end
      end
      default: begin
        next_state = XFER_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state    <= XFER_IDLE;
      cur_addr <= `ADDR_RESET;
    end else begin
      state    <= next_state;
      cur_addr <= next_cur_addr;
    end
  end

  // terminating address and compare flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      end_low    <= `PAGE_LAST;
      next_page  <= 4'h0;
      compare_en <= 1'b0;
    end else if (load_end) begin
      end_low    <= cw_end_low;
      next_page  <= cw_next_page;
      compare_en <= cw_compare;
    end
  end

  // table address, upper seven bits from the channel
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      table_address <= `ADDR_RESET;
    end else if (load_table) begin
      table_address <= {cw_table_hi, `TABLE_LOW};
    end
  end

  // function bits, held until reload or clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      xfer_cfg <= '0;
    end else if (prog_clear) begin
      xfer_cfg <= '0;
    end else if (load_func) begin
      xfer_cfg <= cw_cfg;
    end
  end

  // peripheral code captured while strobe bit 4 is set, sent on clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      periph_code      <= '{is_connect: 1'b0, code: `CODE_RESET};
      periph_code_send <= 1'b0;
    end else begin
      if (connected && stb_level[`STB_SEND]) begin
        periph_code <= '{is_connect: cw_is_connect,
                         code:       cw_code};
      end
      periph_code_send <= send_code;
    end
  end

  // memory request per word unless references are disabled
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_bus <= '0;
    end else begin
      mem_bus.req  <= word_step & ~xfer_cfg.no_mem;
      mem_bus.we   <= xfer_cfg.write;
      mem_bus.addr <= cur_addr;
    end
  end

  // bank phase counter advances on every word
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase_count <= `PHASE_RESET;
    end else if (prog_clear) begin
      phase_count <= `PHASE_RESET;
    end else if (word_step) begin
      phase_count <= 3'(phase_count + phase_step);
    end
  end

  // sticky parity flags; a new error beats the clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sticky_mem_err  <= 1'b0;
      sticky_read_err <= 1'b0;
    end else begin
      sticky_mem_err  <= (mem_parity_err & running & xfer_cfg.write)
                         | (sticky_mem_err & ~prog_clear);
      sticky_read_err <= (read_parity_err & running)
                         | (sticky_read_err & ~prog_clear);
    end
  end

  // page boundary and compare flags; a new event beats the clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      page_empty      <= 1'b0;
      address_compare <= 1'b0;
    end else begin
      page_empty      <= page_jump
                         | (page_empty & ~load_end & ~prog_clear);
      address_compare <= compare_stop
                         | (address_compare & ~load_func
                            & ~prog_clear);
    end
  end

  // status words
  wire  [2:0]  common_bits   = {|irq_lines,
                                sticky_mem_err,
                                sticky_read_err};
  wire  [15:0] addr_status   = {2'b00, common_bits,
                                cur_addr[10:0]};
  wire  [15:0] dflt_status   = {2'b00, common_bits,
                                irq_lines,
                                assembly_count,
                                phase_count};
  wire  [15:0] next_status   = !connected ? `STATUS_RESET
                               : addr_sel ? addr_status
                               : dflt_status;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_word <= `STATUS_RESET;
    end else begin
      status_word <= next_status;
    end
  end

  assign transfer_active = running;

endmodule // channel_interface_control_port

// ---- dv/channel_interface_control_port_properties.sv ----
// pin-level assertions for the channel interface control port
// assumes bind onto channel_interface_control_port, one clock domain
`timescale 1ns/1ps
module channel_interface_control_port_properties
  import chan_port_pkg::*;
(
  input wire logic         core_clk,
  input wire logic         rst,
  input wire logic         channel_select,
  input wire logic [15:0]  control_word,
  input wire logic [15:0]  strobe_word,
  input wire logic [15:0]  status_word,
  input wire logic [3:0]   irq_lines,
  input wire logic [3:0]   assembly_count,
  input wire logic         word_strobe,
  input wire logic         end_of_record,
  input wire logic         read_parity_err,
  input wire mem_req_t     mem_bus,
  input wire xfer_cfg_t    xfer_cfg,
  input wire logic [14:0]  table_address,
  input wire periph_code_t periph_code,
  input wire logic         periph_code_send,
  input wire logic         transfer_active
);
  wire conn = strobe_word[3:0] == (channel_select ? 4'hd : 4'hc);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_status_idle: assert property (
    !conn |=> status_word == 16'h0000) else $error("status while idle");
  a_status_default: assert property (
    conn && !strobe_word[9] |=> status_word[13] == |$past(irq_lines) &&
    status_word[10:3] == {$past(irq_lines), $past(assembly_count)})
    else $error("default status wrong");
  a_table_load: assert property (
    conn && $rose(strobe_word[10]) |=>
    table_address == {~$past(control_word[14:8]), 8'h00})
    else $error("table address wrong");
  a_func_load: assert property (
    conn && $rose(strobe_word[13]) && !strobe_word[12] |=>
    xfer_cfg == {$past(control_word[15:14]), $past(control_word[12:9])})
    else $error("function bits wrong");
  a_clear_all: assert property (
    conn && strobe_word[12] |=> xfer_cfg == 6'h00 && !transfer_active)
    else $error("clear ignored");
  a_code_send: assert property (
    conn && $fell(strobe_word[11]) |=> periph_code_send &&
    periph_code == {$past(control_word[13]), $past(control_word[11:0])})
    else $error("code not sent");
  a_mem_dir: assert property (
    transfer_active && word_strobe && !xfer_cfg.no_mem && !strobe_word[12]
    |=> mem_bus.req && mem_bus.we == $past(xfer_cfg.write))
    else $error("memory request wrong");
  a_eor_stop: assert property (
    transfer_active && end_of_record |=> !transfer_active)
    else $error("end of record ignored");
  a_parity_stop: assert property (
    transfer_active && xfer_cfg.halt_err && read_parity_err
    |=> !transfer_active) else $error("parity halt ignored");
endmodule // channel_interface_control_port_properties

bind channel_interface_control_port
  channel_interface_control_port_properties chk (
  .core_clk(core_clk), .rst(rst), .channel_select(channel_select),
  .control_word(control_word), .strobe_word(strobe_word),
  .status_word(status_word), .irq_lines(irq_lines),
  .assembly_count(assembly_count), .word_strobe(word_strobe),
  .end_of_record(end_of_record), .read_parity_err(read_parity_err),
  .mem_bus(mem_bus), .xfer_cfg(xfer_cfg), .table_address(table_address),
  .periph_code(periph_code), .periph_code_send(periph_code_send),
  .transfer_active(transfer_active));

// ---- dv/processor_model.sv ----
// station control processor model driving control and strobe channels
// assumes changes at the falling edge of core_clk
`timescale 1ns/1ps
module processor_model (
  input  wire logic        core_clk,
  output logic      [15:0] control_word,
  output logic      [15:0] strobe_word
);
  initial begin
    control_word = 16'h0000;
    strobe_word = 16'h0000;
  end
  task automatic connect(input logic [3:0] code);
    @(negedge core_clk);
    strobe_word[3:0] = code;
  endtask
  task automatic level(input int b, input logic v);
    @(negedge core_clk);
    strobe_word[15-b] = v;
  endtask
  task automatic pulse(input int b, input logic [15:0] cw);
    @(negedge core_clk);
    control_word = cw;
    strobe_word[15-b] = 1'b1;
    @(negedge core_clk);
    strobe_word[15-b] = 1'b0;
    @(negedge core_clk);
    control_word = ~cw;
  endtask
  task automatic load_addr(input int b, input logic f, input logic [14:0] a);
    pulse(b, {f, ~a});
  endtask
endmodule // processor_model

// ---- dv/test_channel_interface_control_port.sv ----
// self-checking bench for the channel interface control port
// assumes processor_model drives the control and strobe channels
`timescale 1ns/1ps
module test_channel_interface_control_port;
  import chan_port_pkg::*;
  logic         core_clk = 1'b0;
  logic         rst = 1'b1;
  logic         channel_select = 1'b0;
  logic [3:0]   irq_lines = 4'ha;
  logic [3:0]   assembly_count = 4'h5;
  logic         word_strobe = 1'b0;
  logic         end_of_record = 1'b0;
  logic         read_parity_err = 1'b0;
  logic         mem_parity_err = 1'b0;
  logic         write_parity_err = 1'b0;
  logic [15:0]  control_word;
  logic [15:0]  strobe_word;
  logic [15:0]  status_word;
  mem_req_t     mem_bus;
  xfer_cfg_t    xfer_cfg;
  logic [14:0]  table_address;
  periph_code_t periph_code;
  periph_code_t sent_code;
  logic         periph_code_send;
  logic         transfer_active;
  logic         page_empty;
  logic         address_compare;
  int           n_mismatch = 0;
  int           n_tests = 0;
  int           sends = 0;
  int           cycles = 0;

  processor_model m (.core_clk(core_clk), .control_word(control_word),
    .strobe_word(strobe_word));
  channel_interface_control_port dut (.core_clk(core_clk), .rst(rst),
    .channel_select(channel_select), .control_word(control_word),
    .strobe_word(strobe_word), .status_word(status_word),
    .irq_lines(irq_lines), .assembly_count(assembly_count),
    .word_strobe(word_strobe), .end_of_record(end_of_record),
    .mem_parity_err(mem_parity_err), .read_parity_err(read_parity_err),
    .write_parity_err(write_parity_err), .mem_bus(mem_bus),
    .xfer_cfg(xfer_cfg),
    .table_address(table_address), .periph_code(periph_code),
    .periph_code_send(periph_code_send),
    .transfer_active(transfer_active), .page_empty(page_empty),
    .address_compare(address_compare));

  initial forever #20 core_clk = ~core_clk;

  always @(negedge core_clk) begin
    cycles++;
    if (periph_code_send === 1'b1) begin
      sends++;
      sent_code = periph_code;
    end
    if (cycles == 2000) begin
      n_mismatch++;
      $display("mismatch at %0t: timeout", $time);
      final_report();
    end
  end

  task automatic final_report;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic word(input logic [14:0] addr, input logic req);
    @(negedge core_clk);
    word_strobe = 1'b1;
    @(negedge core_clk);
    word_strobe = 1'b0;
    check({15'h0, mem_bus.req}, {15'h0, req}, "request");
    if (req) check({1'b0, mem_bus.addr}, {1'b0, addr}, "address");
  endtask

  task automatic s_connect;
    m.connect(4'hd);
    tick(2);
    check(status_word, 16'h0000, "idle");
    m.connect(4'hc);
    tick(2);
    check(status_word, 16'h2528, "default");
    channel_select = 1'b1;
    m.connect(4'hd);
    tick(2);
    check(status_word, 16'h2528, "channel one");
    channel_select = 1'b0;
    m.connect(4'hc);
  endtask

  task automatic s_load;
    m.load_addr(0, 1'b0, 15'h1234);
    m.level(6, 1'b1);
    tick(1);
    check(status_word, 16'h2234, "start");
    m.level(6, 1'b0);
    m.load_addr(5, 1'b0, 15'h5a00);
    check({1'b0, table_address}, 16'h5a00, "table");
  endtask

  task automatic s_code;
    for (int c = 0; c < 2; c++) begin
      m.pulse(4, {2'b00, c[0], 1'b0, 12'ha5c ^ {12{c[0]}}});
      tick(1);
      check({3'h0, sent_code}, {3'h0, c[0], 12'ha5c ^ {12{c[0]}}},
            "code");
      check(16'(sends), 16'(c + 1), "sends");
    end
  endtask

  task automatic s_write;
    m.load_addr(0, 1'b0, 15'h0100);
    m.load_addr(1, 1'b1, 15'h0102);
    m.pulse(2, 16'h4000);
    check({9'h0, transfer_active, xfer_cfg}, 16'h0050, "write");
    word(15'h0100, 1'b1);
    word(15'h0101, 1'b1);
    word(15'h0102, 1'b1);
    tick(1);
    check({14'h0, transfer_active, address_compare}, 16'h1,
          "cmp");
  endtask

  task automatic s_page;
    m.load_addr(0, 1'b0, 15'h0ffe);
    m.load_addr(1, 1'b0, 15'h1800);
    m.pulse(2, 16'h4000);
    word(15'h0ffe, 1'b1);
    word(15'h0fff, 1'b1);
    check({15'h0, page_empty}, 16'h1, "page");
    word(15'h1800, 1'b1);
    m.pulse(2, 16'hda00);
    check({10'h0, xfer_cfg}, 16'h003d, "modes");
    m.level(3, 1'b1);
    tick(1);
    check({9'h0, transfer_active, xfer_cfg}, 16'h0, "clear");
    m.level(3, 1'b0);
  endtask

  task automatic s_read;
    m.load_addr(0, 1'b0, 15'h0200);
    m.load_addr(1, 1'b1, 15'h0201);
    m.pulse(2, 16'h0000);
    word(15'h0200, 1'b1);
    word(15'h0201, 1'b1);
    word(15'h0202, 1'b1);
    check({14'h0, transfer_active, address_compare}, 16'h2, "read");
    @(negedge core_clk) end_of_record = 1'b1;
    @(negedge core_clk) end_of_record = 1'b0;
    check({15'h0, transfer_active}, 16'h0, "record");
  endtask

  task automatic s_halt;
    m.pulse(2, 16'h4c00);
    check({10'h0, xfer_cfg}, 16'h0016, "halt cfg");
    word(15'h0000, 1'b0);
    @(negedge core_clk) read_parity_err = 1'b1;
    @(negedge core_clk) read_parity_err = 1'b0;
    check({15'h0, transfer_active}, 16'h0, "halt");
    m.level(6, 1'b1);
    tick(1);
    check({5'h0, status_word[10:0]}, 16'h0204, "step");
    m.level(6, 1'b0);
    m.pulse(2, 16'h4c00);
    @(negedge core_clk) mem_parity_err = 1'b1;
    @(negedge core_clk) mem_parity_err = 1'b0;
    check({15'h0, transfer_active}, 16'h0, "memory halt");
    m.pulse(2, 16'h4c00);
    @(negedge core_clk) write_parity_err = 1'b1;
    @(negedge core_clk) write_parity_err = 1'b0;
    check({15'h0, transfer_active}, 16'h0, "write halt");
    tick(1);
    check(status_word, 16'h3d2c, "errors");
  endtask

  task automatic s_back;
    m.load_addr(0, 1'b0, 15'h0801);
    m.load_addr(1, 1'b0, 15'h2000);
    m.pulse(2, 16'h0200);
    check({10'h0, xfer_cfg}, 16'h0001, "backward");
    word(15'h0801, 1'b1);
    word(15'h0800, 1'b1);
    check({15'h0, page_empty}, 16'h1, "back page");
    word(15'h27ff, 1'b1);
    @(negedge core_clk) end_of_record = 1'b1;
    @(negedge core_clk) end_of_record = 1'b0;
    irq_lines = 4'h0;
    tick(1);
    check(status_word, 16'h182f, "quiet");
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    s_connect();
    s_load();
    s_code();
    s_write();
    s_page();
    s_read();
    s_halt();
    s_back();
    final_report();
  end
endmodule // test_channel_interface_control_port
